// File: prot_word_pkg.sv
// Constants and types for the flash protection word decoder.
// Assumes a flash macro with a word-addressed information block read port.
package prot_word_pkg;

    // Information block placement
    localparam logic [1:0]  INFO_BLOCK_SEL   = 2'h2;   // Block 2
    localparam logic [7:0]  PROT_WORD_ADDR   = 8'hfe;  // Protection word
    localparam logic [7:0]  REV_COPY_ADDR    = 8'h7c;  // Revision copy
    localparam logic [7:0]  PARAM_COUNT_ADDR = 8'h02;  // Parameter count

    // Field positions inside the protection word
    localparam int BOOT_LSB      = 0;
    localparam int BOOT_MSB      = 3;
    localparam int HOST_BOOT_BIT = 4;
    localparam int RTC_LOCK_BIT  = 5;
    localparam int MBT_ZERO_BIT  = 6;
    localparam int PROT_LSB      = 7;
    localparam int PROT_MSB      = 9;
    localparam int RST2_LSB      = 14;
    localparam int RST2_MSB      = 15;

    // Field codes
    localparam logic [3:0]  BOOT_CODE_4K  = 4'he;
    localparam logic [3:0]  BOOT_CODE_8K  = 4'hd;
    localparam logic [2:0]  PROT_OPEN     = 3'h7;
    localparam logic [2:0]  PROT_LOCKED   = 3'h0;
    localparam logic [1:0]  RST2_PIN_A    = 2'h1;
    localparam logic [1:0]  RST2_PIN_B    = 2'h2;
    localparam logic [1:0]  RST2_OFF      = 2'h3;
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam logic [15:0] WORD_RESET    = 16'h0000;

    // Boot block size as decoded
    typedef enum logic [1:0] {
        BOOT_NONE,
        BOOT_4K,
        BOOT_8K
    } boot_size_t;

    // Decoded system defaults
    typedef struct packed {
        boot_size_t boot_size;        // Core boot block size
        logic       host_boot_block;  // Host boot block in use
        logic       mbt_force_zero;   // Force memory base translation zero
        logic       rtc_lock_default; // Host blocked from RTC at reset
        logic       flash_protected;  // Contents guarded
        logic       flash_production; // Fully locked production code
        logic [1:0] rst2_sel;         // Secondary reset pin select
    } cfg_t;

endpackage : prot_word_pkg

// File: reset_pin_filter.sv
// Three-stage synchroniser and agreement filter for reset pins.
// Assumes the pins are asynchronous to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module reset_pin_filter #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Raw pins and filtered levels
    input  wire logic [WIDTH-1:0] pin_raw,
    output var  logic [WIDTH-1:0] pin_q
);
    logic [WIDTH-1:0] s1_q;  // First stage, read only by s2
    logic [WIDTH-1:0] s2_q;  // Second stage
    logic [WIDTH-1:0] s3_q;  // Third stage

    // Synchroniser chain; pins idle high (reset inactive)
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Accept a change only when the last two stages agree
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_filt
            always_ff @(posedge ref_clk) begin
                if (rst) begin
                    pin_q[g] <= 1'b1;
                end else if (s2_q[g] == s3_q[g]) begin
                    pin_q[g] <= s3_q[g];
                end
            end
        end
    endgenerate
endmodule : reset_pin_filter
`default_nettype wire

// File: prot_word_decoder.sv
// Flash protection word decoder: fetches the protection word and the
// revision copy from the information block after reset and drives the
// system defaults derived from them.
// Assumes a flash read port that answers a held request with one valid
// pulse, and reset pins that are asynchronous and active low.
//
// How it works
// [RULE1] Fetch protection word at info block 2, 00FE
// [RULE2] Bits 3-0: 1110 gives 4K, 1101 8K boot
// [RULE3] Bit 4 host boot block, bit 6 base zero
// [RULE4] Bit 5 set blocks host RTC until core enables
// [RULE5] Bits 9-7: 111 unprotected, 000 production protected
// [RULE6] Bits 15-14 route secondary reset: A, B, off
// [RULE7] Guard flash writes, refuse running erased flash
// [RULE8] Tool writes protection word last over JTAG
// [RULE9] Tool updates word in all four environments
// [RULE10] Firmware loads ADC table: count at 0002
// [RULE11] Revision copy fetched from info word 007C
`timescale 1ns/1ns
`default_nettype none
module prot_word_decoder
    import prot_word_pkg::*;
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rst,
    // Information block read port
    output var  logic               ib_rd_req_q,
    output var  logic [1:0]         ib_block_q,
    output var  logic [7:0]         ib_addr_q,
    input  wire logic               ib_rd_valid,
    input  wire logic [15:0]        ib_rd_data,
    // Decoded defaults
    output var  prot_word_pkg::cfg_t cfg_q,
    output var  logic [15:0]        flash_protection_word_q,
    output var  logic [15:0]        silicon_revision_indication_q,
    output var  logic               cfg_valid_q,
    // Core and RTC control
    input  wire logic               rtc_host_enable,
    output var  logic               rtc_host_access_q,
    output var  logic               core_run_q,
    // Flash alteration request from the programming path
    input  wire logic               flash_wr_req,
    output var  logic               flash_wr_grant_q,
    // Reset pins, active low
    input  wire logic               primary_reset_input_n,
    input  wire logic               secondary_reset_input_a_n,
    input  wire logic               secondary_reset_input_b_n,
    output var  logic               system_reset_q
);
    import prot_word_pkg::*;

    // Loader states
    typedef enum logic [2:0] {
        LD_PROT_REQ,
        LD_PROT_WAIT,
        LD_REV_REQ,
        LD_REV_WAIT,
        LD_DONE
    } load_state_t;

    load_state_t state_q;         // Loader state
    load_state_t state_d;         // Next loader state
    logic [2:0]  pins_q;          // Filtered reset pins
    logic        sec_reset_act;   // Selected secondary reset asserted
    cfg_t        cfg_new;         // Decode of the incoming word

    // Split the protection word into its fields
    function automatic cfg_t decode_word(input logic [15:0] w);
        cfg_t c;
        c = '0;
        case (w[BOOT_MSB:BOOT_LSB])                          // [RULE2]
            BOOT_CODE_4K: c.boot_size = BOOT_4K;
            BOOT_CODE_8K: c.boot_size = BOOT_8K;
            default:      c.boot_size = BOOT_NONE;
        endcase
        c.host_boot_block  = w[HOST_BOOT_BIT];                // [RULE3]
        c.mbt_force_zero   = w[MBT_ZERO_BIT];                 // [RULE3]
        c.rtc_lock_default = w[RTC_LOCK_BIT];                 // [RULE4]
        // Any code other than all ones guards the contents
        c.flash_protected  = (w[PROT_MSB:PROT_LSB] != PROT_OPEN); // [RULE5]
        c.flash_production = (w[PROT_MSB:PROT_LSB] == PROT_LOCKED);
        c.rst2_sel         = w[RST2_MSB:RST2_LSB];            // [RULE6]
        return c;
    endfunction : decode_word

    assign cfg_new = decode_word(ib_rd_data);

    // Loader next state; request held until the flash answers
    always_comb begin
        state_d = state_q;
        case (state_q)
            LD_PROT_REQ:  state_d = LD_PROT_WAIT;
            LD_PROT_WAIT: begin
                if (ib_rd_valid) begin
                    state_d = LD_REV_REQ;
                end
            end
            LD_REV_REQ:   state_d = LD_REV_WAIT;
            LD_REV_WAIT: begin
                if (ib_rd_valid) begin
                    state_d = LD_DONE;
                end
            end
            LD_DONE:      state_d = LD_DONE;
            default:      state_d = LD_PROT_REQ;
        endcase
    end

    // Loader state register; one fetch pass per reset
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_q <= LD_PROT_REQ;
        end else begin
            state_q <= state_d;
        end
    end

    // Flash read port drive
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ib_rd_req_q <= 1'b0;
            ib_block_q  <= 2'h0;
            ib_addr_q   <= 8'h00;
        end else begin
            case (state_d)
                LD_PROT_REQ, LD_PROT_WAIT: begin
                    ib_rd_req_q <= 1'b1;
                    ib_block_q  <= INFO_BLOCK_SEL;               // [RULE1]
                    ib_addr_q   <= PROT_WORD_ADDR;               // [RULE1]
                end
                LD_REV_REQ, LD_REV_WAIT: begin
                    ib_rd_req_q <= 1'b1;
                    ib_block_q  <= INFO_BLOCK_SEL;
                    ib_addr_q   <= REV_COPY_ADDR;                // [RULE11]
                end
                default: begin
                    ib_rd_req_q <= 1'b0;
                    ib_block_q  <= 2'h0;
                    ib_addr_q   <= 8'h00;
                end
            endcase
        end
    end

    // Capture the protection word and its decode
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_protection_word_q <= WORD_RESET;
            cfg_q                   <= '0;
        end else if (state_q == LD_PROT_WAIT && ib_rd_valid) begin
            flash_protection_word_q <= ib_rd_data;               // [RULE1]
            cfg_q                   <= cfg_new;
        end
    end

    // Capture the revision copy for software
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            silicon_revision_indication_q <= WORD_RESET;
        end else if (state_q == LD_REV_WAIT && ib_rd_valid) begin
            silicon_revision_indication_q <= ib_rd_data;         // [RULE11]
        end
    end

    // Defaults become valid once both words are in
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_valid_q <= 1'b0;
        end else begin
            cfg_valid_q <= (state_d == LD_DONE);
        end
    end

    // Core runs only from a programmed flash; erased reads all ones
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            core_run_q <= 1'b0;
        end else begin
            core_run_q <= (state_d == LD_DONE) &&
                          (flash_protection_word_q != ERASED_WORD); // [RULE7]
        end
    end

    // Host RTC access: default from bit 5, opened by the core.
    // The enable wins over a load in the same cycle; an enable before the load is overwritten.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rtc_host_access_q <= 1'b0;
        end else if (rtc_host_enable) begin
            rtc_host_access_q <= 1'b1;                           // [RULE4]
        end else if (state_q == LD_PROT_WAIT && ib_rd_valid) begin
            rtc_host_access_q <= !cfg_new.rtc_lock_default;      // [RULE4]
        end
    end

    // Alteration is refused until the decode is known and while guarded
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            flash_wr_grant_q <= 1'b0;
        end else begin
            flash_wr_grant_q <= flash_wr_req && cfg_valid_q &&
                                !cfg_q.flash_protected;          // [RULE7]
        end
    end

    // Reset pins pass the three-stage filter
    reset_pin_filter #(
        .WIDTH (3)
    ) u_pin_filter (
        .ref_clk (ref_clk),
        .rst     (rst),
        .pin_raw ({secondary_reset_input_b_n,
                   secondary_reset_input_a_n,
                   primary_reset_input_n}),
        .pin_q   (pins_q)
    );

    // Secondary reset routing; code 00 is treated as disabled
    always_comb begin
        case (cfg_q.rst2_sel)                                    // [RULE6]
            RST2_PIN_A: sec_reset_act = !pins_q[1];
            RST2_PIN_B: sec_reset_act = !pins_q[2];
            default:    sec_reset_act = 1'b0;
        endcase
    end

    // Combined system reset; secondary ignored before decode is valid
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            system_reset_q <= 1'b0;
        end else begin
            system_reset_q <= !pins_q[0] ||
                              (cfg_valid_q && sec_reset_act);    // [RULE6]
        end
    end

    // Checks
    a_fetch_addr_prot: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == LD_PROT_WAIT |-> ib_rd_req_q && ib_block_q == 2'h2
        && ib_addr_q == 8'hfe)                                   // [RULE1]
        else $error("protection word fetch address wrong");
    a_boot_4k_decode: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == LD_PROT_WAIT && ib_rd_valid && ib_rd_data[3:0] == 4'he
        |=> cfg_q.boot_size == BOOT_4K)                          // [RULE2]
        else $error("4K boot code not decoded");
    a_boot_8k_decode: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == LD_PROT_WAIT && ib_rd_valid && ib_rd_data[3:0] == 4'hd
        |=> cfg_q.boot_size == BOOT_8K)                          // [RULE2]
        else $error("8K boot code not decoded");
    a_host_boot_bits: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_valid_q |-> cfg_q.host_boot_block == flash_protection_word_q[4]
        && cfg_q.mbt_force_zero == flash_protection_word_q[6])   // [RULE3]
        else $error("host boot bits mismatch");
    a_rtc_lock_hold: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_valid_q && !rtc_host_access_q && !rtc_host_enable
        |=> !rtc_host_access_q)                                  // [RULE4]
        else $error("host RTC access opened without core");
    a_rtc_core_open: assert property (@(posedge ref_clk) disable iff (rst)
        rtc_host_enable |=> rtc_host_access_q)                   // [RULE4]
        else $error("core enable did not open RTC");
    a_protect_field: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_valid_q |-> cfg_q.flash_protected ==
        (flash_protection_word_q[9:7] != 3'h7))                  // [RULE5]
        else $error("protection field decode wrong");
    a_write_refused: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_q.flash_protected || !cfg_valid_q |=> !flash_wr_grant_q) // [RULE7]
        else $error("write granted on guarded flash");
    a_erased_no_run: assert property (@(posedge ref_clk) disable iff (rst)
        core_run_q |-> flash_protection_word_q != 16'hffff)      // [RULE7]
        else $error("core runs from erased flash");
    a_rst2_off: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_q.rst2_sel == 2'h3 && pins_q[0] && $stable(cfg_q)
        |=> !system_reset_q)                                     // [RULE6]
        else $error("disabled secondary reset acted");
    a_rev_capture: assert property (@(posedge ref_clk) disable iff (rst)
        state_q == LD_REV_WAIT && ib_rd_valid |-> ib_addr_q == 8'h7c
        ##1 silicon_revision_indication_q == $past(ib_rd_data))  // [RULE11]
        else $error("revision copy not captured");
endmodule : prot_word_decoder
`default_nettype wire

// File: flash_info_model.sv
// Behavioural flash information block that answers the decoder's reads.
// Assumes the decoder holds each request until it sees one valid pulse.
`timescale 1ns/1ns
`default_nettype none
module flash_info_model
    import prot_word_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Read port from the decoder
    input  wire logic        ib_rd_req_q,
    input  wire logic [1:0]  ib_block_q,
    input  wire logic [7:0]  ib_addr_q,
    output var  logic        ib_rd_valid,
    output var  logic [15:0] ib_rd_data,
    // Contents and answer delay chosen by the bench
    input  wire logic [15:0] prot_word,  // Left by the tool
    input  wire logic [15:0] rev_word,
    input  wire logic [3:0]  latency     // Edges before the answer, 1 or more
);
    logic [7:0] last_addr = 8'h00;  // Address seen at the previous edge
    logic [3:0] wait_cnt  = 4'h0;   // Edges the current request has waited
    logic       served    = 1'b0;   // Current request already answered
    // Element count for the firmware's calibration table; arbitrary value
    localparam logic [15:0] PARAM_COUNT = 16'h0004;

    initial ib_rd_valid = 1'b0;
    initial ib_rd_data  = 16'h0000;

    // Answer each held request once, after the chosen delay
    always @(posedge ref_clk) begin
        ib_rd_valid <= 1'b0;
        // Released data keeps toggling so a stale capture cannot pass
        ib_rd_data  <= ~ib_rd_data;
        last_addr   <= ib_addr_q;
        if (rst || !ib_rd_req_q || ib_addr_q != last_addr) begin
            wait_cnt <= 4'h0;
            served   <= 1'b0;
        end else if (!served && wait_cnt + 4'h1 >= latency) begin
            served      <= 1'b1;
            ib_rd_valid <= 1'b1;
            // Only block 2 holds the factory words
            if (ib_block_q != INFO_BLOCK_SEL)
                ib_rd_data <= 16'hdead;
            else if (ib_addr_q == PROT_WORD_ADDR)
                ib_rd_data <= prot_word;
            else if (ib_addr_q == REV_COPY_ADDR)
                ib_rd_data <= rev_word;
            else if (ib_addr_q == PARAM_COUNT_ADDR)
                ib_rd_data <= PARAM_COUNT;
            else
                ib_rd_data <= 16'hbeef;
        end else if (!served) begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
endmodule : flash_info_model
`default_nettype wire

// File: prot_word_decoder_bench.sv
// Self-checking bench for the protection word decoder.
// Assumes the flash model above and inputs driven at the falling edge.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(what, exp, got) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
        error_cnt++; \
        $display("Error %s expected %h seen %h", what, exp, got); \
    end \
end
module prot_word_decoder_bench;
    import prot_word_pkg::*;

    // Clock, reset and flash model settings
    logic        ref_clk   = 1'b0;
    logic        rst       = 1'b1;
    logic [15:0] prot_word = 16'h0000;
    logic [15:0] rev_word  = 16'h5a3c;  // Arbitrary revision copy value
    logic [3:0]  latency   = 4'h1;
    // Decoder ports
    logic        ib_rd_req_q;
    logic [1:0]  ib_block_q;
    logic [7:0]  ib_addr_q;
    logic        ib_rd_valid;
    logic [15:0] ib_rd_data;
    cfg_t        cfg_q;
    logic [15:0] flash_protection_word_q;
    logic [15:0] silicon_revision_indication_q;
    logic        cfg_valid_q;
    logic        rtc_host_enable  = 1'b0;
    logic        rtc_host_access_q;
    logic        core_run_q;
    logic        flash_wr_req     = 1'b0;
    logic        flash_wr_grant_q;
    logic [2:0]  pin_n            = 3'h7;  // Primary, secondary A, B
    logic        system_reset_q;
    // Scoreboard
    int          error_cnt        = 0;
    int          samples_checked  = 0;
    logic        timed_out        = 1'b0;  // A load never completed

    prot_word_decoder i_dut (
        .ref_clk(ref_clk), .rst(rst),
        .ib_rd_req_q(ib_rd_req_q), .ib_block_q(ib_block_q),
        .ib_addr_q(ib_addr_q), .ib_rd_valid(ib_rd_valid),
        .ib_rd_data(ib_rd_data), .cfg_q(cfg_q),
        .flash_protection_word_q(flash_protection_word_q),
        .silicon_revision_indication_q(silicon_revision_indication_q),
        .cfg_valid_q(cfg_valid_q), .rtc_host_enable(rtc_host_enable),
        .rtc_host_access_q(rtc_host_access_q), .core_run_q(core_run_q),
        .flash_wr_req(flash_wr_req), .flash_wr_grant_q(flash_wr_grant_q),
        .primary_reset_input_n(pin_n[0]),
        .secondary_reset_input_a_n(pin_n[1]),
        .secondary_reset_input_b_n(pin_n[2]),
        .system_reset_q(system_reset_q));

    flash_info_model i_flash (
        .ref_clk(ref_clk), .rst(rst), .ib_rd_req_q(ib_rd_req_q),
        .ib_block_q(ib_block_q), .ib_addr_q(ib_addr_q),
        .ib_rd_valid(ib_rd_valid), .ib_rd_data(ib_rd_data),
        .prot_word(prot_word), .rev_word(rev_word), .latency(latency));

    // 10 MHz clock
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    // Step to the next falling edge, where inputs change
    task automatic cycles(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cycles

    // Single closing point for pass, fail and timeout
    task automatic give_verdict();
        $display("Checked %0d, errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : give_verdict

    // Reset, let the word load, then probe every decoded default
    task automatic run_word(input logic [15:0] w, input logic [3:0] lat);
        boot_size_t exp_boot;
        logic       exp_pin;
        int         k;
        exp_boot = (w[3:0] == 4'he) ? BOOT_4K :
                   (w[3:0] == 4'hd) ? BOOT_8K : BOOT_NONE;
        prot_word = w;
        latency   = lat;
        rst       = 1'b1;
        cycles(3);
        rst = 1'b0;
        cycles(1);
        `CHECK("fetch request", 1'b1, ib_rd_req_q)
        `CHECK("fetch block", INFO_BLOCK_SEL, ib_block_q)
        `CHECK("fetch address", PROT_WORD_ADDR, ib_addr_q)
        // Bounded wait for both words; running out ends the run
        k = 0;
        while (cfg_valid_q !== 1'b1 && k < 50) begin
            cycles(1);
            k++;
        end
        // Judge by the flag itself so a late but valid load still passes
        if (cfg_valid_q !== 1'b1) begin
            error_cnt++;
            timed_out = 1'b1;
            $display("Error load timeout expected %h seen %h",
                     1'b1, cfg_valid_q);
            return;
        end
        `CHECK("raw word", w, flash_protection_word_q)
        `CHECK("boot size", exp_boot, cfg_q.boot_size)
        `CHECK("host boot", w[4], cfg_q.host_boot_block)
        `CHECK("base zero", w[6], cfg_q.mbt_force_zero)
        `CHECK("rtc lock", w[5], cfg_q.rtc_lock_default)
        `CHECK("rtc access", ~w[5], rtc_host_access_q)
        `CHECK("protected", w[9:7] != 3'h7, cfg_q.flash_protected)
        `CHECK("production", w[9:7] == 3'h0, cfg_q.flash_production)
        `CHECK("reset select", w[15:14], cfg_q.rst2_sel)
        `CHECK("core run", w != ERASED_WORD, core_run_q)
        `CHECK("revision", rev_word, silicon_revision_indication_q)
        `CHECK("fetch done", 1'b0, ib_rd_req_q)
        // Core opens host access to the clock
        rtc_host_enable = 1'b1;
        cycles(1);
        rtc_host_enable = 1'b0;
        cycles(1);
        `CHECK("rtc opened", 1'b1, rtc_host_access_q)
        // Alteration is granted only while unprotected
        flash_wr_req = 1'b1;
        cycles(3);
        `CHECK("write grant", w[9:7] == 3'h7, flash_wr_grant_q)
        flash_wr_req = 1'b0;
        cycles(3);
        `CHECK("write idle", 1'b0, flash_wr_grant_q)
        // Each reset pin in turn; secondary pins follow the select
        for (int p = 0; p < 3; p++) begin
            exp_pin = (p == 0) ? 1'b1 :
                      (p == 1) ? (w[15:14] == RST2_PIN_A) :
                                 (w[15:14] == RST2_PIN_B);
            pin_n[p] = 1'b0;
            cycles(10);
            `CHECK("pin reset", exp_pin, system_reset_q)
            pin_n[p] = 1'b1;
            cycles(10);
            `CHECK("pin released", 1'b0, system_reset_q)
        end
    endtask : run_word

    // Example words, an erased part and an odd mixed setting
    logic [15:0] words [6] = '{16'h7f9e, 16'h7c1e, 16'hbf9d,
                               16'hffbe, 16'hffff, 16'h0140};

    // Main sequence: prompt and slow flash answers alternate
    initial begin
        // A hung load skips the rest and goes straight to the verdict
        for (int i = 0; i < 6 && !timed_out; i++) begin
            run_word(words[i], (i % 2 == 1) ? 4'h6 : 4'h1);
        end
        give_verdict();
    end
endmodule : prot_word_decoder_bench
`undef CHECK
`default_nettype wire
